// ---- hprd_port_cfg.sv ----
// Port removability and port disable configuration for a hub with up to four downstream ports.
// Assumes the hub core loads registers over the byte load port and supplies straps and power mode.
//
// Functional notes
// - Bits 1 to 4 of the non-removable mask mark ports 1 to 4 as holding a fixed device.
// - Bits 0, 5, 6 and 7 of the three mask registers are reserved and steer no port.
// - A set bit 1 to 4 in the self-powered off mask disables that port, a clear bit keeps it.
// - The disable selection applies only while the remap select bit is zero.
// - A disabled port can never be enabled or enumerated by the host.
// - The reported port count equals the number of ports left enabled.
// - Any combination of ports may be disabled, not only the highest ones.
// - The remaining enabled ports are renumbered from one without gaps.
// - In default configuration the fixed device straps choose the non-removable ports.
// - In default configuration the positive and negative off straps choose disabled ports.
// - The bus-powered off mask uses the same encoding as the self-powered one.
// - Bit 3 of configuration byte 3 selects standard mode at zero and remap mode at one.
// - In default configuration any non-removable port makes the hub report compound.
`timescale 1ns/1ps

module hprd_port_cfg import hprd_pkg::*; #(
  parameter int NUM_PORTS = PORT_MAX
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire hprd_cfg_req_type cfg_req,
  input wire logic use_default_cfg,
  input wire logic self_powered,
  input wire logic [1:0] fixed_device_straps,
  input wire logic [PORT_MAX:1] port_off_strap_positive,
  input wire logic [PORT_MAX:1] port_off_strap_negative,
  input wire hprd_host_req_type host_req,
  output logic [7:0] cfg_rd_data,
  output logic cfg_rd_valid,
  output hprd_status_type port_status,
  output hprd_map_type logical_to_phys,
  output logic [PORT_MAX:1] port_active,
  output logic host_refused
);

  // ****************************************************************
  // Elaboration checks and helpers
  // ****************************************************************
  if (NUM_PORTS < PORT_MIN || NUM_PORTS > PORT_MAX) begin : g_bad_ports
    $error("NUM_PORTS must lie between 2 and 4.");
  end

  function automatic logic [PORT_MAX:1] exist_mask(input int n);
    logic [PORT_MAX:1] m;
    m = '0;
    for (int p = 1; p <= PORT_MAX; p++) begin
      m[p] = (p <= n);
    end
    return m;
  endfunction

  function automatic logic [PHYS_W-1:0] popcount(input logic [PORT_MAX:1] mask);
    logic [PHYS_W-1:0] c;
    c = '0;
    for (int p = 1; p <= PORT_MAX; p++) begin
      c = c + PHYS_W'(mask[p]);
    end
    return c;
  endfunction

  // Packs enabled physical ports into logical numbers one upward, any pattern allowed.
  function automatic hprd_map_type build_map(input logic [PORT_MAX:1] mask);
    hprd_map_type m;
    int n;
    m = '0;
    n = 1;
    for (int p = 1; p <= PORT_MAX; p++) begin
      if (mask[p]) begin
        m[n] = PHYS_W'(p);
        n++;
      end
    end
    return m;
  endfunction

  function automatic logic [PORT_MAX:1] strap_fixed(input logic [1:0] s);
    logic [PORT_MAX:1] m;
    case (s)
      STRAP_FIXED_NONE: m = MASK_RESET;
      STRAP_FIXED_P1: m = STRAP_MASK_P1;
      STRAP_FIXED_P12: m = STRAP_MASK_P12;
      default: m = STRAP_MASK_P123;
    endcase
    return m;
  endfunction

  localparam logic [PORT_MAX:1] PORT_EXIST = exist_mask(NUM_PORTS);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [PORT_MAX:1] fixed_q, fixed_d;
  logic [PORT_MAX:1] sp_off_q, sp_off_d;
  logic [PORT_MAX:1] bp_off_q, bp_off_d;
  logic compound_q, compound_d;
  logic remap_q, remap_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;

  always_comb begin
    fixed_d = fixed_q;
    sp_off_d = sp_off_q;
    bp_off_d = bp_off_q;
    compound_d = compound_q;
    remap_d = remap_q;
    rd_data_d = DATA_ZERO;
    rd_valid_d = cfg_req.rd_en;
    if (cfg_req.wr_en) begin
      case (cfg_req.addr)
        ADDR_CFG_BYTE2: compound_d = cfg_req.wdata[COMPOUND_BIT];
        ADDR_CFG_BYTE3: remap_d = cfg_req.wdata[REMAP_BIT];
        ADDR_FIXED_MASK: fixed_d = cfg_req.wdata[PORT_MSB:PORT_LSB];
        ADDR_SP_OFF_MASK: sp_off_d = cfg_req.wdata[PORT_MSB:PORT_LSB];
        ADDR_BP_OFF_MASK: bp_off_d = cfg_req.wdata[PORT_MSB:PORT_LSB];
        default: ;
      endcase
    end
    if (cfg_req.rd_en) begin
      // Reserved bits always read back as zero.
      case (cfg_req.addr)
        ADDR_CFG_BYTE2: rd_data_d[COMPOUND_BIT] = compound_q;
        ADDR_CFG_BYTE3: rd_data_d[REMAP_BIT] = remap_q;
        ADDR_FIXED_MASK: rd_data_d[PORT_MSB:PORT_LSB] = fixed_q;
        ADDR_SP_OFF_MASK: rd_data_d[PORT_MSB:PORT_LSB] = sp_off_q;
        ADDR_BP_OFF_MASK: rd_data_d[PORT_MSB:PORT_LSB] = bp_off_q;
        default: rd_data_d = DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fixed_q <= MASK_RESET;
      sp_off_q <= MASK_RESET;
      bp_off_q <= MASK_RESET;
      compound_q <= FLAG_RESET;
      remap_q <= FLAG_RESET;
      rd_data_q <= DATA_ZERO;
      rd_valid_q <= FLAG_RESET;
    end else begin
      fixed_q <= fixed_d;
      sp_off_q <= sp_off_d;
      bp_off_q <= bp_off_d;
      compound_q <= compound_d;
      remap_q <= remap_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // ****************************************************************
  // Effective port configuration
  // ****************************************************************
  hprd_status_type status_q, status_d;
  hprd_map_type map_q, map_d;
  logic [PORT_MAX:1] off_sel;

  always_comb begin
    off_sel = self_powered ? sp_off_q : bp_off_q;
    status_d = '0;
    if (use_default_cfg) begin
      status_d.fixed = strap_fixed(fixed_device_straps) & PORT_EXIST;
      status_d.enabled = ~(port_off_strap_positive & port_off_strap_negative)
        & PORT_EXIST;
      status_d.compound = |status_d.fixed;
    end else begin
      status_d.fixed = fixed_q & PORT_EXIST;
      status_d.compound = compound_q;
      if (remap_q) begin
        status_d.enabled = PORT_EXIST;
      end else begin
        status_d.enabled = ~off_sel & PORT_EXIST;
      end
    end
    status_d.count = popcount(status_d.enabled);
    map_d = build_map(status_d.enabled);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_q <= '0;
      map_q <= '0;
    end else begin
      status_q <= status_d;
      map_q <= map_d;
    end
  end

  // ****************************************************************
  // Host port enable requests
  // ****************************************************************
  logic [PORT_MAX:1] active_q, active_d;
  logic refused_q, refused_d;
  logic req_ok;
  logic [PHYS_W-1:0] req_phys;

  always_comb begin
    req_ok = (host_req.port != '0) && (host_req.port <= status_q.count);
    req_phys = req_ok ? map_q[host_req.port] : '0;
    active_d = active_q;
    if ((host_req.enable || host_req.turn_off) && req_ok) begin
      active_d[req_phys] = host_req.enable;
    end
    active_d = active_d & status_d.enabled;
    refused_d = (host_req.enable || host_req.turn_off) && !req_ok;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      active_q <= MASK_RESET;
      refused_q <= FLAG_RESET;
    end else begin
      active_q <= active_d;
      refused_q <= refused_d;
    end
  end

  assign cfg_rd_data = rd_data_q;
  assign cfg_rd_valid = rd_valid_q;
  assign port_status = status_q;
  assign logical_to_phys = map_q;
  assign port_active = active_q;
  assign host_refused = refused_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_RSVD_ZERO: assert property (
    rd_valid_q |-> (rd_data_q[0] == 1'b0 && rd_data_q[7:5] == 3'h0))
    else $error("Reserved bits read back non-zero.");

  AST_FIXED_REG: assert property (
    (cfg_req.wr_en && cfg_req.addr == ADDR_FIXED_MASK && !use_default_cfg) ##1
    (!use_default_cfg && !cfg_req.wr_en) |=>
    status_q.fixed == ($past(cfg_req.wdata[PORT_MSB:PORT_LSB], 2) & PORT_EXIST))
    else $error("Fixed port mask does not follow register write.");

  AST_SP_OFF: assert property (
    (!use_default_cfg && self_powered && !remap_q) |=>
    status_q.enabled == ($past(~sp_off_q) & PORT_EXIST))
    else $error("Self-powered disable selection not applied.");

  AST_BP_OFF: assert property (
    (!use_default_cfg && !self_powered && !remap_q) |=>
    status_q.enabled == ($past(~bp_off_q) & PORT_EXIST))
    else $error("Bus-powered disable selection not applied.");

  AST_REMAP_IGNORES: assert property (
    (!use_default_cfg && remap_q) |=> status_q.enabled == PORT_EXIST)
    else $error("Disable selection applied in remap mode.");

  AST_COUNT: assert property (
    status_q.count == PHYS_W'($countones(status_q.enabled)))
    else $error("Port count differs from enabled ports.");

  AST_NO_DISABLED_ACTIVE: assert property (
    (active_q & ~status_q.enabled) == MASK_RESET)
    else $error("Disabled port is active.");

  AST_FIRST_MAPPED: assert property (
    status_q.count != '0 |-> status_q.enabled[map_q[1]])
    else $error("Logical port one maps to a disabled port.");

  AST_STRAP_OFF: assert property (
    use_default_cfg |=> status_q.enabled ==
    ($past(~(port_off_strap_positive & port_off_strap_negative)) & PORT_EXIST))
    else $error("Disable straps not applied.");

  AST_STRAP_FIXED: assert property (
    (use_default_cfg && fixed_device_straps == STRAP_FIXED_NONE) |=>
    status_q.fixed == MASK_RESET)
    else $error("Fixed straps not applied.");

  AST_COMPOUND: assert property (
    use_default_cfg |=> status_q.compound == |status_q.fixed)
    else $error("Compound report does not follow fixed straps.");

  AST_REFUSE: assert property (
    (host_req.enable && host_req.port > status_q.count) |=> host_refused)
    else $error("Request for a missing port was not refused.");

  AST_REFUSE_KEEPS: assert property (
    refused_q |-> active_q == ($past(active_q) & status_q.enabled))
    else $error("Refused request changed the active ports.");

  COV_SPARSE_OFF: cover property (
    status_q.enabled == 4'h5 && status_q.count == 3'h2);
  COV_HOST_ENABLE: cover property (
    host_req.enable && req_ok ##1 active_q != MASK_RESET);
  COV_HOST_DISABLE: cover property (
    host_req.turn_off && req_ok ##1 active_q == MASK_RESET);
  COV_STRAP_COMPOUND: cover property (
    use_default_cfg ##1 status_q.compound);

endmodule // hprd_port_cfg

// ---- hprd_pkg.sv ----
// Shared constants and types for the hub port removability and disable configuration block.
// Assumes one clock domain and an eight-bit configuration load port from the hub core.
package hprd_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int PORT_MAX = 4;
  localparam int PORT_MIN = 2;
  localparam int PHYS_W = 3;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CFG_BYTE2 = 8'h07;
  localparam logic [7:0] ADDR_CFG_BYTE3 = 8'h08;
  localparam logic [7:0] ADDR_FIXED_MASK = 8'h09;
  localparam logic [7:0] ADDR_SP_OFF_MASK = 8'h0A;
  localparam logic [7:0] ADDR_BP_OFF_MASK = 8'h0B;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int COMPOUND_BIT = 3;
  localparam int REMAP_BIT = 3;
  localparam int PORT_LSB = 1;
  localparam int PORT_MSB = 4;
  localparam logic [PORT_MAX:1] MASK_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // ****************************************************************
  // Non-removable strap encodings
  // ****************************************************************
  localparam logic [1:0] STRAP_FIXED_NONE = 2'h0;
  localparam logic [1:0] STRAP_FIXED_P1 = 2'h1;
  localparam logic [1:0] STRAP_FIXED_P12 = 2'h2;
  localparam logic [PORT_MAX:1] STRAP_MASK_P1 = 4'h1;
  localparam logic [PORT_MAX:1] STRAP_MASK_P12 = 4'h3;
  localparam logic [PORT_MAX:1] STRAP_MASK_P123 = 4'h7;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hprd_cfg_req_type;

  typedef struct packed {
    logic enable;
    logic turn_off;
    logic [PHYS_W-1:0] port;
  } hprd_host_req_type;

  typedef struct packed {
    logic [PORT_MAX:1] enabled;
    logic [PORT_MAX:1] fixed;
    logic [PHYS_W-1:0] count;
    logic compound;
  } hprd_status_type;

  typedef logic [PORT_MAX:1][PHYS_W-1:0] hprd_map_type;

endpackage

// ---- hprd_host_model.sv ----
// Host side model that enables and disables logical downstream ports of the hub.
// Assumes one clock and requests driven shortly after the rising edge.
`timescale 1ns/1ps

module hprd_host_model import hprd_pkg::*; (
  input wire logic ref_clk,
  output hprd_host_req_type host_req
);
  initial begin
    host_req = '0;
  end

  // ****************************************
  // Request task
  // ****************************************
  // Issues one request pulse, one clock cycle long, to enable or turn off a logical port.
  task automatic request(input logic en, input logic [PHYS_W-1:0] port);
    @(posedge ref_clk);
    #1;
    host_req = {en, ~en, port};
    @(posedge ref_clk);
    #1;
    host_req = '0;
  endtask
endmodule // hprd_host_model

// ---- tb.sv ----
// Self-checking testbench for the port removability and disable configuration block.
// Assumes the host model file and the package are compiled before this file.
`timescale 1ns/1ps

module tb import hprd_pkg::*;;
  logic ref_clk, rst_n, use_default_cfg, self_powered, cfg_rd_valid, host_refused;
  hprd_cfg_req_type cfg_req;
  hprd_host_req_type host_req;
  logic [1:0] fixed_device_straps;
  logic [PORT_MAX:1] port_off_strap_positive, port_off_strap_negative, port_active;
  logic [7:0] cfg_rd_data;
  hprd_status_type port_status;
  hprd_map_type logical_to_phys;
  int num_errors, checked;
  logic [PORT_MAX:1] fx_tab [4] = '{MASK_RESET, STRAP_MASK_P1, STRAP_MASK_P12, STRAP_MASK_P123};

  hprd_port_cfg #(.NUM_PORTS(PORT_MAX)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req), .use_default_cfg(use_default_cfg),
    .self_powered(self_powered), .fixed_device_straps(fixed_device_straps),
    .port_off_strap_positive(port_off_strap_positive),
    .port_off_strap_negative(port_off_strap_negative), .host_req(host_req),
    .cfg_rd_data(cfg_rd_data), .cfg_rd_valid(cfg_rd_valid), .port_status(port_status),
    .logical_to_phys(logical_to_phys), .port_active(port_active), .host_refused(host_refused)
  );

  hprd_host_model host (.ref_clk(ref_clk), .host_req(host_req));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    cfg_req = {1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    #1;
    cfg_req = '0;
    settle();
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    #1;
    cfg_req = {1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    #1;
    cfg_req = '0;
    cmp({15'h0000, cfg_rd_valid}, 16'h0001);
    cmp({8'h00, cfg_rd_data}, {8'h00, exp});
  endtask

  task automatic chk_status(input logic [3:0] en, input logic [3:0] fx, input logic [2:0] cnt,
                            input logic comp);
    cmp({4'h0, port_status}, {4'h0, en, fx, cnt, comp});
  endtask

  task automatic chk_map(input logic [11:0] exp);
    cmp({4'h0, logical_to_phys}, {4'h0, exp});
  endtask

  task automatic chk_host(input logic refused, input logic [3:0] active);
    cmp({11'h000, host_refused, port_active}, {11'h000, refused, active});
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    cfg_req = '0;
    use_default_cfg = 1'b0;
    self_powered = 1'b1;
    fixed_device_straps = 2'h3;
    port_off_strap_positive = 4'hF;
    port_off_strap_negative = 4'hF;
    num_errors = 0;
    checked = 0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    settle();
    chk_status(4'hF, 4'h0, 3'h4, 1'b0);
    reg_read(ADDR_FIXED_MASK, 8'h00);
    reg_read(ADDR_SP_OFF_MASK, 8'h00);
    reg_read(ADDR_BP_OFF_MASK, 8'h00);
    reg_read(8'hC0, 8'h00);
    reg_write(8'h20, 8'hFF);
    chk_status(4'hF, 4'h0, 3'h4, 1'b0);
    reg_write(ADDR_SP_OFF_MASK, 8'h04);
    chk_status(4'hD, 4'h0, 3'h3, 1'b0);
    chk_map({3'h0, 3'h4, 3'h3, 3'h1});
    reg_read(ADDR_SP_OFF_MASK, 8'h04);
    host.request(1'b1, 3'h2);
    chk_host(1'b0, 4'h4);
    host.request(1'b1, 3'h4);
    chk_host(1'b1, 4'h4);
    host.request(1'b1, 3'h0);
    chk_host(1'b1, 4'h4);
    reg_write(ADDR_SP_OFF_MASK, 8'h0C);
    chk_host(1'b0, 4'h0);
    chk_status(4'h9, 4'h0, 3'h2, 1'b0);
    host.request(1'b1, 3'h3);
    chk_host(1'b1, 4'h0);
    reg_write(ADDR_SP_OFF_MASK, 8'hE1);
    chk_status(4'hF, 4'h0, 3'h4, 1'b0);
    reg_read(ADDR_SP_OFF_MASK, 8'h00);
    reg_write(ADDR_SP_OFF_MASK, 8'h0A);
    chk_status(4'hA, 4'h0, 3'h2, 1'b0);
    chk_map({3'h0, 3'h0, 3'h4, 3'h2});
    host.request(1'b1, 3'h2);
    chk_host(1'b0, 4'h8);
    host.request(1'b0, 3'h2);
    chk_host(1'b0, 4'h0);
    self_powered = 1'b0;
    reg_write(ADDR_BP_OFF_MASK, 8'h10);
    chk_status(4'h7, 4'h0, 3'h3, 1'b0);
    chk_map({3'h0, 3'h3, 3'h2, 3'h1});
    reg_write(ADDR_CFG_BYTE3, 8'h08);
    chk_status(4'hF, 4'h0, 3'h4, 1'b0);
    chk_map({3'h4, 3'h3, 3'h2, 3'h1});
    reg_write(ADDR_CFG_BYTE3, 8'hF7);
    chk_status(4'h7, 4'h0, 3'h3, 1'b0);
    reg_write(ADDR_FIXED_MASK, 8'h13);
    chk_status(4'h7, 4'h9, 3'h3, 1'b0);
    reg_read(ADDR_FIXED_MASK, 8'h12);
    reg_write(ADDR_CFG_BYTE2, 8'h08);
    chk_status(4'h7, 4'h9, 3'h3, 1'b1);
    use_default_cfg = 1'b1;
    port_off_strap_positive = 4'h2;
    port_off_strap_negative = 4'h6;
    for (int i = 0; i < 4; i++) begin
      fixed_device_straps = i[1:0];
      settle();
      chk_status(4'hD, fx_tab[i], 3'h3, i != 0);
    end
    rst_n = 1'b0;
    use_default_cfg = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    settle();
    chk_status(4'hF, 4'h0, 3'h4, 1'b0);
    chk_map({3'h4, 3'h3, 3'h2, 3'h1});
    chk_host(1'b0, 4'h0);
    reg_read(ADDR_FIXED_MASK, 8'h00);
    reg_read(ADDR_BP_OFF_MASK, 8'h00);
    report_and_stop();
  end
endmodule // tb
